// ===== hw/pfi_pkg.sv
package pfi_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] FEATURE_ID_OFFSET = 12'h000;
  localparam logic [63:0] FEATURE_ID_RESET  = 64'h0000_0000_0000_0000;
  localparam int          INST_W            = 4;
  localparam int          INST_NUM          = 16;

  // ------------------------------------------------------------------
  // field positions of feature_identification
  // ------------------------------------------------------------------
  localparam int MAX_INST_LSB    = 56;
  localparam int NO_CUSTOM_BIT   = 36;
  localparam int HAS_SEL_BIT     = 32;
  localparam int HAS_NARROW_BIT  = 31;
  localparam int HAS_MON_BIT     = 30;
  localparam int HAS_CUSTOM_BIT  = 29;
  localparam int EXT_BIT         = 28;
  localparam int HAS_PRI_BIT     = 27;
  localparam int HAS_BW_BIT      = 26;
  localparam int HAS_CPOR_BIT    = 25;
  localparam int HAS_CCAP_BIT    = 24;
  localparam int MAX_PMG_LSB     = 16;
  localparam int MAX_PARTITION_IDENTIFIER_LSB  = 0;

  // feature pages, one register instance per page
  typedef enum logic [1:0] {
    PFI_PAGE_SECURE  = 2'h0,
    PFI_PAGE_NONSEC  = 2'h1,
    PFI_PAGE_ROOT    = 2'h2,
    PFI_PAGE_REALM   = 2'h3
  } pfi_page_t;

  // one access from the feature page decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    pfi_page_t   page;
    logic [11:0] addr;
  } pfi_req_t;

  // controls that belong to one resource instance
  typedef struct packed {
    logic no_custom;
    logic pri;
    logic bw;
    logic cpor;
    logic ccap;
  } pfi_inst_flags_t;

endpackage

// ===== hw/pfi_inst_table.sv
// per-instance control presence, selected by the partition select register
module pfi_inst_table #(
  parameter logic [15:0] NO_CUSTOM_VEC = 16'hffff,
  parameter logic [15:0] PRI_VEC       = 16'h0001,
  parameter logic [15:0] BW_VEC        = 16'h0001,
  parameter logic [15:0] CPOR_VEC      = 16'h0001,
  parameter logic [15:0] CCAP_VEC      = 16'h0001
) (
  input  wire logic [pfi_pkg::INST_W-1:0] sel_i,
  output pfi_pkg::pfi_inst_flags_t        flags_o
);

  pfi_pkg::pfi_inst_flags_t table_q [pfi_pkg::INST_NUM];

  // ------------------------------------------------------------------
  // constant table, one entry per instance
  // ------------------------------------------------------------------
  for (genvar g = 0; g < pfi_pkg::INST_NUM; g++) begin : g_inst
    assign table_q[g] = '{no_custom: NO_CUSTOM_VEC[g], pri: PRI_VEC[g],
                          bw: BW_VEC[g], cpor: CPOR_VEC[g], ccap: CCAP_VEC[g]};
  end

  // lookup is pure wiring, so a new selection shows on the next read
  assign flags_o = table_q[sel_i];

endmodule // pfi_inst_table

// ===== hw/pfi_feature_id.sv
// Notes on behaviour
// - custom-controls flag sits at bit 36
// - bit 36 zero means custom controls exist
// - bit 36 follows the selected instance
// - bit 32 reports instance selector presence
// - bit 31 reports identifier narrowing support
// - bit 30 reports usage monitor support
// - bit 29 reports custom feature register
// - bit 28 says upper word is defined
// - bit 27 reports priority control
// - bit 26 reports bandwidth control
// - bit 25 reports cache portion control
// - bit 24 reports cache capacity control
// - control flags follow the selected instance
// - bits 23:16 give page's monitor group limit
// - bits 15:0 give page's identifier limit
// - secure page may report either limit
// - 64 bits when extended revision, else 32
// - read-only, separate instance per page
// - only instance fields track the selector
module pfi_feature_id #(
  parameter bit          REG_IS_64           = 1'b1,
  parameter bit          EXT_LAYOUT          = 1'b1,
  parameter bit          HAS_SELECTOR        = 1'b1,
  parameter logic [3:0]  MAX_INSTANCE        = 4'h3,
  parameter bit          HAS_NARROWING       = 1'b0,
  parameter bit          HAS_MONITORS        = 1'b1,
  parameter bit          HAS_CUSTOM_REG      = 1'b1,
  parameter logic [7:0]  MAX_PMG_NS          = 8'h01,
  parameter logic [15:0] MAX_PARTITION_IDENTIFIER_NS       = 16'h003f,
  parameter logic [7:0]  MAX_PMG_SEC         = 8'h00,
  parameter logic [15:0] MAX_PARTITION_IDENTIFIER_SEC      = 16'h000f,
  parameter logic [7:0]  MAX_PMG_ROOT        = 8'h00,
  parameter logic [15:0] MAX_PARTITION_IDENTIFIER_ROOT     = 16'h0003,
  parameter logic [7:0]  MAX_PMG_REALM       = 8'h01,
  parameter logic [15:0] MAX_PARTITION_IDENTIFIER_REALM    = 16'h001f,
  parameter bit          SEC_PAGE_SHOWS_SEC  = 1'b1
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire pfi_pkg::pfi_req_t          req_i,
  input  wire logic [pfi_pkg::INST_W-1:0] part_sel_instance_i,
  output logic                            rd_valid_o,
  output logic [63:0]                     rd_data_o
);

  pfi_pkg::pfi_inst_flags_t          inst_flags;
  logic [pfi_pkg::INST_W-1:0]        eff_sel;
  logic [63:0]                       next_word;
  logic                              hit;

  // ------------------------------------------------------------------
  // instance selection
  // ------------------------------------------------------------------
  // without a selector every read describes instance 0, the whole component
  assign eff_sel = HAS_SELECTOR ? part_sel_instance_i : '0;

  // instances 0 to 3 each own a different mix of controls, so a swapped or
  // stuck flag shows on a read; instance 1 alone has custom controls
  pfi_inst_table #(
    .NO_CUSTOM_VEC (16'hfffd),
    .PRI_VEC       (16'h0003),
    .BW_VEC        (16'h0005),
    .CPOR_VEC      (16'h0009),
    .CCAP_VEC      (16'h0001)
  ) u_table (
    .sel_i   (eff_sel),
    .flags_o (inst_flags)
  );

  // ------------------------------------------------------------------
  // word assembly
  // ------------------------------------------------------------------
  // page limits; the secure page choice is fixed at build time
  function automatic logic [23:0] page_limits(input pfi_pkg::pfi_page_t pg);
    case (pg)
      pfi_pkg::PFI_PAGE_SECURE:
        page_limits = SEC_PAGE_SHOWS_SEC ? {MAX_PMG_SEC, MAX_PARTITION_IDENTIFIER_SEC}
                                         : {MAX_PMG_NS, MAX_PARTITION_IDENTIFIER_NS};
      pfi_pkg::PFI_PAGE_NONSEC: page_limits = {MAX_PMG_NS, MAX_PARTITION_IDENTIFIER_NS};
      pfi_pkg::PFI_PAGE_ROOT:   page_limits = {MAX_PMG_ROOT, MAX_PARTITION_IDENTIFIER_ROOT};
      default:                  page_limits = {MAX_PMG_REALM, MAX_PARTITION_IDENTIFIER_REALM};
    endcase
  endfunction

  // every bit not set below is reserved and stays zero
  always_comb begin
    logic [23:0] lim;
    lim       = page_limits(req_i.page);
    next_word = pfi_pkg::FEATURE_ID_RESET;
    next_word[pfi_pkg::HAS_NARROW_BIT] = HAS_NARROWING;
    next_word[pfi_pkg::HAS_MON_BIT]    = HAS_MONITORS;
    next_word[pfi_pkg::HAS_CUSTOM_BIT] = HAS_CUSTOM_REG;
    next_word[pfi_pkg::HAS_PRI_BIT]    = inst_flags.pri;
    next_word[pfi_pkg::HAS_BW_BIT]     = inst_flags.bw;
    next_word[pfi_pkg::HAS_CPOR_BIT]   = inst_flags.cpor;
    next_word[pfi_pkg::HAS_CCAP_BIT]   = inst_flags.ccap;
    next_word[pfi_pkg::MAX_PMG_LSB +: 8]    = lim[23:16];
    next_word[pfi_pkg::MAX_PARTITION_IDENTIFIER_LSB +: 16] = lim[15:0];
    if (REG_IS_64) begin
      next_word[pfi_pkg::EXT_BIT] = EXT_LAYOUT;
      if (EXT_LAYOUT) begin
        next_word[pfi_pkg::HAS_SEL_BIT] = HAS_SELECTOR;
        if (HAS_SELECTOR) begin
          next_word[pfi_pkg::MAX_INST_LSB +: pfi_pkg::INST_W] = MAX_INSTANCE;
        end
        if (HAS_CUSTOM_REG) begin
          next_word[pfi_pkg::NO_CUSTOM_BIT] = inst_flags.no_custom;
        end
      end
    end
  end

  assign hit = req_i.rd && (req_i.addr == pfi_pkg::FEATURE_ID_OFFSET);

  // ------------------------------------------------------------------
  // read port
  // ------------------------------------------------------------------
  // writes never reach the data path, so a write has no side effect
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
    end
  end

  // unmapped addresses answer zero; a 32-bit build never shows the upper word
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= pfi_pkg::FEATURE_ID_RESET;
    end else if (req_i.rd) begin
      rd_data_o <= hit ? (REG_IS_64 ? next_word : {32'h0, next_word[31:0]})
                       : pfi_pkg::FEATURE_ID_RESET;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  reserved_zero_a: assert property (rd_valid_o |-> rd_data_o[35:33] == 3'h0
                                    && rd_data_o[55:37] == 19'h0 && rd_data_o[63:60] == 4'h0)
    else $error("reserved bits not zero");

  write_ignored_a: assert property (!req_i.rd ##1 1'b1 |-> $stable(rd_data_o))
    else $error("read data changed without a read");

  read_answer_a: assert property (req_i.rd |=> rd_valid_o)
    else $error("read not answered next cycle");

  narrow_upper_a: assert property (rd_valid_o && !REG_IS_64 |-> rd_data_o[63:32] == '0
                                   && !rd_data_o[pfi_pkg::EXT_BIT])
    else $error("32-bit build shows upper bits");

  selector_bit_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_SEL_BIT] ==
                                   (REG_IS_64 && EXT_LAYOUT && HAS_SELECTOR))
    else $error("selector flag wrong");

  custom_flag_a: assert property (hit |=> rd_data_o[pfi_pkg::NO_CUSTOM_BIT] ==
                                  (REG_IS_64 && EXT_LAYOUT && HAS_CUSTOM_REG
                                   && $past(inst_flags.no_custom)))
    else $error("custom-controls flag wrong");

  track_inst_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_PRI_BIT] ==
                                 $past(inst_flags.pri))
    else $error("priority flag does not track instance");

  partition_identifier_page_a: assert property (hit && req_i.page == pfi_pkg::PFI_PAGE_NONSEC
                                  |=> rd_data_o[15:0] == MAX_PARTITION_IDENTIFIER_NS)
    else $error("identifier limit wrong for page");

  monitors_bit_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_MON_BIT] == HAS_MONITORS)
    else $error("monitor flag wrong");

  // flags that are fixed by the build and never follow the selector
  ext_flag_a: assert property (hit |=> rd_data_o[pfi_pkg::EXT_BIT] ==
                               (REG_IS_64 && EXT_LAYOUT))
    else $error("extended layout flag wrong");

  narrow_flag_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_NARROW_BIT] ==
                                  HAS_NARROWING)
    else $error("narrowing flag wrong");

  custom_reg_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_CUSTOM_BIT] ==
                                 HAS_CUSTOM_REG)
    else $error("custom feature register flag wrong");

  inst_max_a: assert property (hit |=>
                               rd_data_o[pfi_pkg::MAX_INST_LSB +: pfi_pkg::INST_W] ==
                               ((REG_IS_64 && EXT_LAYOUT && HAS_SELECTOR) ?
                                MAX_INSTANCE : 4'h0))
    else $error("maximum instance field wrong");

  // controls that belong to the instance chosen at the read edge
  bw_track_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_BW_BIT] ==
                               $past(inst_flags.bw))
    else $error("bandwidth flag does not track instance");

  cpor_track_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_CPOR_BIT] ==
                                 $past(inst_flags.cpor))
    else $error("cache portion flag does not track instance");

  ccap_track_a: assert property (hit |=> rd_data_o[pfi_pkg::HAS_CCAP_BIT] ==
                                 $past(inst_flags.ccap))
    else $error("cache capacity flag does not track instance");

  // page limits; the secure page may show either space
  max_group_a: assert property (hit && req_i.page == pfi_pkg::PFI_PAGE_NONSEC
                                |=> rd_data_o[23:16] == MAX_PMG_NS)
    else $error("monitor group limit wrong for page");

  root_limits_a: assert property (hit && req_i.page == pfi_pkg::PFI_PAGE_ROOT
                                  |=> rd_data_o[23:0] == {MAX_PMG_ROOT, MAX_PARTITION_IDENTIFIER_ROOT})
    else $error("root page limits wrong");

  realm_limits_a: assert property (hit && req_i.page == pfi_pkg::PFI_PAGE_REALM
                                   |=> rd_data_o[23:0] == {MAX_PMG_REALM, MAX_PARTITION_IDENTIFIER_REALM})
    else $error("realm page limits wrong");

  secure_limits_a: assert property (hit && req_i.page == pfi_pkg::PFI_PAGE_SECURE
                                    |=> rd_data_o[23:0] == {MAX_PMG_SEC, MAX_PARTITION_IDENTIFIER_SEC}
                                        || rd_data_o[23:0] == {MAX_PMG_NS, MAX_PARTITION_IDENTIFIER_NS})
    else $error("secure page limits match neither space");

  // read port timing and unmapped offsets
  unmapped_zero_a: assert property (req_i.rd && req_i.addr != pfi_pkg::FEATURE_ID_OFFSET
                                    |=> rd_data_o == 64'h0)
    else $error("unmapped offset gave data");

  valid_pulse_a: assert property (!req_i.rd |=> !rd_valid_o)
    else $error("answer without a read");

endmodule // pfi_feature_id

// ===== sim/pfi_feature_id_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // signals and device
  // ------------------------------------------------------------------
  logic                       sys_clk_i;
  logic                       rst_i;
  pfi_pkg::pfi_req_t          req_i;
  logic [pfi_pkg::INST_W-1:0] part_sel_instance_i;
  logic                       rd_valid_o;
  logic [63:0]                rd_data_o;
  int                         bad_count;
  int                         samples_checked;

  pfi_feature_id u_dut (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .req_i               (req_i),
    .part_sel_instance_i (part_sel_instance_i),
    .rd_valid_o          (rd_valid_o),
    .rd_data_o           (rd_data_o)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // word for the default build; instance 0 owns all four controls, 1 to 3
  // one each, and instance 1 alone has custom controls
  function automatic logic [63:0] expect_word(input pfi_pkg::pfi_page_t pg,
                                              input logic [3:0] inst);
    logic [63:0] w;
    w = 64'h0300_0011_7000_0000;
    w[36] = (inst != 4'h1);
    case (inst)
      4'h0:    w[27:24] = 4'hf;
      4'h1:    w[27:24] = 4'h8;
      4'h2:    w[27:24] = 4'h4;
      4'h3:    w[27:24] = 4'h2;
      default: w[27:24] = 4'h0;
    endcase
    case (pg)
      pfi_pkg::PFI_PAGE_SECURE: w[23:0] = 24'h00_000f;
      pfi_pkg::PFI_PAGE_NONSEC: w[23:0] = 24'h01_003f;
      pfi_pkg::PFI_PAGE_ROOT:   w[23:0] = 24'h00_0003;
      default:                  w[23:0] = 24'h01_001f;
    endcase
    return w;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
      bad_count++;
    end
  endtask

  // one read; answer is sampled 1 ns after the taking edge
  task automatic read_reg(input pfi_pkg::pfi_page_t pg, input logic [11:0] a,
                          input logic [3:0] inst, input logic [63:0] exp_w);
    @(posedge sys_clk_i);
    #1;
    req_i = '{rd: 1'b1, wr: 1'b0, page: pg, addr: a};
    part_sel_instance_i = inst;
    @(posedge sys_clk_i);
    #1;
    req_i.rd = 1'b0;
    check({63'h0, rd_valid_o}, 64'h1);
    check(rd_data_o, exp_w);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // a hang would otherwise never reach the verdict
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    bad_count++;
    print_verdict();
  end

  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    req_i = '0;
    part_sel_instance_i = 4'h0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    check({63'h0, rd_valid_o}, 64'h0);
    check(rd_data_o, 64'h0);
    rst_i = 1'b0;
    $display("test reset done");
    // every page against every instance number, selector beyond maximum too
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 16; i++) begin
        read_reg(pfi_pkg::pfi_page_t'(p), 12'h000, 4'(i),
                 expect_word(pfi_pkg::pfi_page_t'(p), 4'(i)));
      end
    end
    $display("test page and instance sweep done");
    // a write strobe must give no answer and change nothing
    @(posedge sys_clk_i);
    #1;
    req_i = '{rd: 1'b0, wr: 1'b1, page: pfi_pkg::PFI_PAGE_NONSEC, addr: 12'h000};
    part_sel_instance_i = 4'h2;
    @(posedge sys_clk_i);
    #1;
    req_i.wr = 1'b0;
    check({63'h0, rd_valid_o}, 64'h0);
    check(rd_data_o, expect_word(pfi_pkg::PFI_PAGE_REALM, 4'hf));
    read_reg(pfi_pkg::PFI_PAGE_NONSEC, 12'h000, 4'h2,
             expect_word(pfi_pkg::PFI_PAGE_NONSEC, 4'h2));
    $display("test write ignored done");
    // offsets other than the register answer with zero
    read_reg(pfi_pkg::PFI_PAGE_SECURE, 12'h008, 4'h0, 64'h0);
    read_reg(pfi_pkg::PFI_PAGE_ROOT, 12'hff8, 4'h0, 64'h0);
    $display("test unmapped offsets done");
    // two reads back to back, then the answer must drop after one cycle
    @(posedge sys_clk_i);
    #1;
    req_i = '{rd: 1'b1, wr: 1'b0, page: pfi_pkg::PFI_PAGE_SECURE, addr: 12'h000};
    part_sel_instance_i = 4'h0;
    @(posedge sys_clk_i);
    #1;
    req_i.page = pfi_pkg::PFI_PAGE_REALM;
    part_sel_instance_i = 4'h1;
    check(rd_data_o, expect_word(pfi_pkg::PFI_PAGE_SECURE, 4'h0));
    @(posedge sys_clk_i);
    #1;
    req_i.rd = 1'b0;
    check({63'h0, rd_valid_o}, 64'h1);
    check(rd_data_o, expect_word(pfi_pkg::PFI_PAGE_REALM, 4'h1));
    @(posedge sys_clk_i);
    #1;
    check({63'h0, rd_valid_o}, 64'h0);
    $display("test back to back reads done");
    print_verdict();
  end

endmodule // testbench
